//--- dac_link_pkg.sv
/*
 * Shared constants for the serial converter link: word layout, frame
 * length, counter decode values and host timing.
 * Assumes a 50 MHz host clock; the converter end runs on the link clock.
 */
`default_nettype none

package dac_link_pkg;

    // ==================================================================
    // Word and frame layout
    // ==================================================================
    localparam int WORD_BITS = 12;
    localparam int COUNT_W = 4;
    localparam int NUM_CONV = 4;
    localparam int ADDR_W = 2;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 4'h0;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 4'h1;
    // Counter value once twelve bits have been shifted (1011).
    localparam logic [COUNT_W-1:0] LAST_BIT_COUNT = 4'hB;
    // Counter value while the load strobe is low (1100); the strobe is driven from the decode of 1011.
    localparam logic [COUNT_W-1:0] LOAD_COUNT = 4'hC;
    // Clock pulses in one frame: twelve data bits plus the load pulse.
    localparam logic [COUNT_W-1:0] FRAME_PULSES = 4'hD;
    localparam logic [WORD_BITS-1:0] WORD_ZERO = 12'h000;

    // ==================================================================
    // Host timing
    // ==================================================================
    localparam int MCLK_PERIOD_NS = 20;
    localparam int CLEAR_TIME_MS = 10;
    localparam int CLEAR_CYCLES = CLEAR_TIME_MS * 1000000 / MCLK_PERIOD_NS;
    localparam int TIMER_W = 20;
    // Host clock cycles per link clock phase; the clock is low for one phase and high for two.
    localparam logic [TIMER_W-1:0] LINK_HALF_CYCLES = 20'h00002;
    // Cycles the select lines rest before a decoded frame and after every frame.
    localparam logic [TIMER_W-1:0] SELECT_SETTLE_CYCLES = 20'h00002;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 20'h00000;
    localparam logic [TIMER_W-1:0] TIMER_ONE = 20'h00001;
    localparam logic [NUM_CONV-1:0] SELECT_NONE_N = 4'hF;
    localparam logic [NUM_CONV-1:0] SELECT_ALL_N = 4'h0;
    localparam logic [NUM_CONV-1:0] SELECT_ONE = 4'h1;

    // Host sequencer states.
    typedef enum logic [2:0] {
        S_CLEAR,
        S_IDLE,
        S_SELECT,
        S_SETUP,
        S_LOW,
        S_HIGH,
        S_RELEASE
    } host_state_e;

endpackage : dac_link_pkg

`default_nettype wire

//--- dac_link_if.sv
/*
 * Wires between the remote host and the converter end: shift clock,
 * serial data, decoded selects and the shared power-up clear.
 * Assumes the host drives every signal; no load strobe crosses the link.
 */
`timescale 1ns/100ps
`default_nettype none

interface dac_link_if;
    import dac_link_pkg::*;

    // ==================================================================
    // Link signals
    // ==================================================================
    logic link_clk;
    logic serial_data_in;
    logic [NUM_CONV-1:0] select_n;
    logic clear_n;

    // Host end drives the link.
    modport host (
        output link_clk,
        output serial_data_in,
        output select_n,
        output clear_n
    );

    // Converter end only listens.
    modport dac (
        input link_clk,
        input serial_data_in,
        input select_n,
        input clear_n
    );

endinterface : dac_link_if

`default_nettype wire

//--- dac_load_end.sv
/*
 * Converter end: local bit counter, load strobe decode and one shift
 * register plus output register per attached converter.
 * Assumes it runs only on the link clock and is cleared by clear_n.
 */
`timescale 1ns/100ps
`default_nettype none

module dac_load_end
    import dac_link_pkg::*;
(
    // Link from the host.
    dac_link_if.dac link,
    // Converter outputs and local strobe.
    output logic [NUM_CONV-1:0][WORD_BITS-1:0] o_dac_code,
    output logic o_load_strobe_n
);

    // ==================================================================
    // Local counter and load strobe
    // ==================================================================
    logic dac_shift_clk;
    logic [COUNT_W-1:0] bit_count;
    logic [COUNT_W-1:0] next_bit_count;
    logic load_strobe_n;
    logic next_load_strobe_n;
    logic load_now;

    // The converters sample on the falling edge of the link clock.
    assign dac_shift_clk = ~link.link_clk;

    // Twelve bits are in when the count reads 1011 with no strobe yet.
    assign load_now = load_strobe_n && (bit_count == LAST_BIT_COUNT);

    // Count rising edges; the strobe presets the counter to zero.
    always_comb begin
        next_bit_count = bit_count;
        next_load_strobe_n = 1'b1;
        if (!load_strobe_n) begin
            next_bit_count = COUNT_ZERO;
        end else begin
            next_bit_count = bit_count + COUNT_ONE;
            if (load_now) begin
                next_load_strobe_n = 1'b0;
            end
        end
    end

    // Counter and strobe are held clear by the shared clear line.
    always_ff @(posedge link.link_clk or negedge link.clear_n) begin
        if (!link.clear_n) begin
            bit_count <= COUNT_ZERO;
            load_strobe_n <= 1'b1;
        end else begin
            bit_count <= next_bit_count;
            load_strobe_n <= next_load_strobe_n;
        end
    end

    assign o_load_strobe_n = load_strobe_n;

    // ==================================================================
    // Per-converter shift and output registers
    // ==================================================================
    genvar g;
    generate
        for (g = 0; g < NUM_CONV; g++) begin : g_conv
            logic [WORD_BITS-1:0] shift_word;
            logic [WORD_BITS-1:0] next_shift_word;
            logic [WORD_BITS-1:0] dac_word;
            logic [WORD_BITS-1:0] next_dac_word;

            // Shift MSB first while selected; the strobe blocks the
            // thirteenth falling edge so no extra bit enters.
            always_comb begin
                next_shift_word = shift_word;
                if (!link.select_n[g] && load_strobe_n) begin
                    next_shift_word = {shift_word[WORD_BITS-2:0],
                                       link.serial_data_in};
                end
            end

            // Only a selected converter takes the word on the load edge.
            always_comb begin
                next_dac_word = dac_word;
                if (!link.select_n[g] && load_now) begin
                    next_dac_word = shift_word;
                end
            end

            // Shift register runs on the inverted clock.
            always_ff @(posedge dac_shift_clk or negedge link.clear_n) begin
                if (!link.clear_n) begin
                    shift_word <= WORD_ZERO;
                end else begin
                    shift_word <= next_shift_word;
                end
            end

            // Clear forces zero scale at once, with no clock edge.
            always_ff @(posedge link.link_clk or negedge link.clear_n) begin
                if (!link.clear_n) begin
                    dac_word <= WORD_ZERO;
                end else begin
                    dac_word <= next_dac_word;
                end
            end

            assign o_dac_code[g] = dac_word;
        end
    endgenerate

endmodule : dac_load_end

`default_nettype wire

//--- dac_host_end.sv
/*
 * Remote host end: power-up clear, link clock divider, select decoder
 * and the thirteen-pulse frame sequencer.
 * Assumes a 50 MHz i_mclk and a user that holds a request until taken.
 */
`timescale 1ns/100ps
`default_nettype none

module dac_host_end
    import dac_link_pkg::*;
#(
    parameter int P_CLEAR_CYCLES = CLEAR_CYCLES
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Write request from the user.
    input wire logic i_req_valid,
    input wire logic [WORD_BITS-1:0] i_req_word,
    input wire logic [ADDR_W-1:0] i_req_addr,
    input wire logic i_req_decode,
    output logic o_req_ready,
    output logic o_done,
    // Link to the converter end.
    dac_link_if.host link
);

    // ==================================================================
    // Sequencer state
    // ==================================================================
    host_state_e state;
    host_state_e next_state;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    logic [COUNT_W-1:0] pulse;
    logic [COUNT_W-1:0] next_pulse;
    logic [WORD_BITS-1:0] word;
    logic [WORD_BITS-1:0] next_word;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic decode;
    logic next_decode;
    logic link_clk;
    logic next_link_clk;
    logic data;
    logic next_data;
    logic [NUM_CONV-1:0] select_n;
    logic [NUM_CONV-1:0] next_select_n;
    logic clear_n;
    logic next_clear_n;
    logic ready;
    logic next_ready;
    logic done;
    logic next_done;
    logic half_over;

    // One phase of the link clock, a third of its period, has elapsed.
    assign half_over = (timer == LINK_HALF_CYCLES - TIMER_ONE);

    // Next-state logic for the whole host sequencer.
    always_comb begin
        next_state = state;
        next_timer = timer + TIMER_ONE;
        next_pulse = pulse;
        next_word = word;
        next_addr = addr;
        next_decode = decode;
        next_link_clk = link_clk;
        next_data = data;
        next_select_n = select_n;
        next_clear_n = clear_n;
        next_ready = ready;
        next_done = 1'b0;
        case (state)
            S_CLEAR: begin
                // Hold the shared clear until the supply has settled.
                next_clear_n = 1'b0;
                next_link_clk = 1'b1;
                if (timer == TIMER_W'(P_CLEAR_CYCLES) - TIMER_ONE) begin
                    next_clear_n = 1'b1;
                    next_ready = 1'b1;
                    next_timer = TIMER_ZERO;
                    next_state = S_IDLE;
                end
            end
            S_IDLE: begin
                // Clock rests high between frames.
                next_link_clk = 1'b1;
                next_timer = TIMER_ZERO;
                if (i_req_valid) begin
                    next_word = i_req_word;
                    // Address n picks converter n, 0 to 3, when decoding.
                    next_addr = i_req_addr;
                    next_decode = i_req_decode;
                    next_ready = 1'b0;
                    next_pulse = COUNT_ZERO;
                    if (i_req_decode) begin
                        next_select_n = SELECT_NONE_N;
                        next_state = S_SELECT;
                    end else begin
                        next_select_n = SELECT_ALL_N;
                        next_state = S_SETUP;
                    end
                end
            end
            S_SELECT: begin
                // Address is steady with the decoder off; then enable.
                if (timer == SELECT_SETTLE_CYCLES - TIMER_ONE) begin
                    next_select_n = ~(SELECT_ONE << addr);
                    next_timer = TIMER_ZERO;
                    next_state = S_SETUP;
                end
            end
            S_SETUP: begin
                // Present the next bit, MSB first, while the clock is high.
                if (timer == TIMER_ZERO) begin
                    next_data = word[WORD_BITS-1];
                    next_word = {word[WORD_BITS-2:0], 1'b0};
                end
                if (half_over) begin
                    next_timer = TIMER_ZERO;
                    next_state = S_LOW;
                end
            end
            S_LOW: begin
                // Falling edge: the converters sample the data bit.
                next_link_clk = 1'b0;
                if (half_over) begin
                    next_timer = TIMER_ZERO;
                    next_state = S_HIGH;
                end
            end
            S_HIGH: begin
                // Rising edge: the local counter advances.
                next_link_clk = 1'b1;
                if (half_over) begin
                    next_timer = TIMER_ZERO;
                    if (pulse == FRAME_PULSES - COUNT_ONE) begin
                        next_state = S_RELEASE;
                    end else begin
                        next_pulse = pulse + COUNT_ONE;
                        next_state = S_SETUP;
                    end
                end
            end
            S_RELEASE: begin
                // Clock already high before any select is raised.
                next_link_clk = 1'b1;
                if (timer == SELECT_SETTLE_CYCLES - TIMER_ONE) begin
                    if (decode) begin
                        next_select_n = SELECT_NONE_N;
                    end
                    next_data = 1'b0;
                    next_done = 1'b1;
                    next_ready = 1'b1;
                    next_timer = TIMER_ZERO;
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_CLEAR;
                next_timer = TIMER_ZERO;
            end
        endcase
    end

    // Register the sequencer; reset restarts the power-up clear.
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            state <= S_CLEAR;
            timer <= TIMER_ZERO;
            pulse <= COUNT_ZERO;
            word <= WORD_ZERO;
            addr <= '0;
            decode <= 1'b0;
            link_clk <= 1'b1;
            data <= 1'b0;
            select_n <= SELECT_NONE_N;
            clear_n <= 1'b0;
            ready <= 1'b0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            pulse <= next_pulse;
            word <= next_word;
            addr <= next_addr;
            decode <= next_decode;
            link_clk <= next_link_clk;
            data <= next_data;
            select_n <= next_select_n;
            clear_n <= next_clear_n;
            ready <= next_ready;
            done <= next_done;
        end
    end

    // ==================================================================
    // Outputs, each straight from a flip-flop
    // ==================================================================
    // Only clock and data carry the frame; the strobe is made locally.
    assign link.link_clk = link_clk;
    assign link.serial_data_in = data;
    assign link.select_n = select_n;
    assign link.clear_n = clear_n;
    assign o_req_ready = ready;
    assign o_done = done;

endmodule : dac_host_end

`default_nettype wire

//--- dac_link_props.sv
/*
 * Checker for the serial converter link: clock shape, data and select
 * timing around the shift clock, and the power-up clear.
 * Assumes it is instantiated beside the link interface in the bench.
 */
`timescale 1ns/100ps
`default_nettype none

module dac_link_props
    import dac_link_pkg::*;
#(
    parameter int P_CLEAR_CYCLES = CLEAR_CYCLES
) (
    // Host clock and reset.
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Link signals.
    input wire logic link_clk,
    input wire logic serial_data_in,
    input wire logic [NUM_CONV-1:0] select_n,
    input wire logic clear_n
);
    // ==================================================================
    // Clear length counter
    // ==================================================================
    int clr_cnt;
    int next_clr_cnt;

    // Counts the cycles that clear is held low after reset.
    always_comb begin
        next_clr_cnt = clr_cnt;
        if (!clear_n) next_clr_cnt = clr_cnt + 1;
    end

    // Registers the count; reset starts it again.
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) clr_cnt <= 0;
        else clr_cnt <= next_clr_cnt;
    end

    // ==================================================================
    // Properties
    // ==================================================================
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    property p_fall_low;
        $fell(link_clk) |=> !link_clk ##1 link_clk;
    endproperty
    property p_rise_high; $rose(link_clk) |=> link_clk [*3]; endproperty
    property p_data_high; $changed(serial_data_in) |-> link_clk; endproperty
    property p_sel_low; !link_clk |-> $stable(select_n); endproperty
    property p_sel_edge;
        $changed(select_n) |-> link_clk && $past(link_clk);
    endproperty
    property p_one_sel;
        (select_n == SELECT_ALL_N) || ($countones(select_n) >= NUM_CONV - 1);
    endproperty
    property p_clear_idle;
        !clear_n |-> link_clk && (select_n == SELECT_NONE_N);
    endproperty
    property p_clear_len;
        $rose(clear_n) |-> clr_cnt >= P_CLEAR_CYCLES
            && clr_cnt <= P_CLEAR_CYCLES + 2;
    endproperty
    property p_clear_stays; $past(clear_n) |-> clear_n; endproperty

    a_fall_low: assert property (p_fall_low)
        else $error("link clock low phase is not two cycles");
    a_rise_high: assert property (p_rise_high)
        else $error("link clock high phase too short");
    a_data_high: assert property (p_data_high)
        else $error("serial data changed while clock low");
    a_sel_low: assert property (p_sel_low)
        else $error("select changed while clock low");
    a_sel_edge: assert property (p_sel_edge)
        else $error("select changed without clock high");
    a_one_sel: assert property (p_one_sel)
        else $error("more than one converter selected");
    a_clear_idle: assert property (p_clear_idle)
        else $error("link active during clear");
    a_clear_len: assert property (p_clear_len)
        else $error("clear held for wrong length");
    a_clear_stays: assert property (p_clear_stays)
        else $error("clear reasserted without reset");

    // Main scenarios: clear release, shared and decoded frames.
    c_clear: cover property ($rose(clear_n));
    c_shared: cover property ($fell(link_clk) && select_n == SELECT_ALL_N);
    c_decoded: cover property ($fell(link_clk) && select_n != SELECT_ALL_N);
endmodule : dac_link_props

`default_nettype wire

//--- serial_dac_load_sequencer_tb_top.sv
/*
 * Testbench: host end and converter end joined by the link interface,
 * driven through the host request port and judged at both user sides.
 * Assumes the design package and interface are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module serial_dac_load_sequencer_tb_top;
    import dac_link_pkg::*;
    // ==================================================================
    // Signals and instances
    // ==================================================================
    localparam int CLR = 8;
    logic i_mclk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_req_valid = 1'b0;
    logic [WORD_BITS-1:0] i_req_word = WORD_ZERO;
    logic [ADDR_W-1:0] i_req_addr = 2'h0;
    logic i_req_decode = 1'b0;
    logic o_req_ready;
    logic o_done;
    logic [NUM_CONV-1:0][WORD_BITS-1:0] o_dac_code;
    logic o_load_strobe_n;
    logic [WORD_BITS-1:0] exp_code [NUM_CONV];
    logic [WORD_BITS-1:0] wire_word;
    int bad_count = 0;
    int checked = 0;
    int rises = 0;
    int falls = 0;
    int strobe_lo = 0;

    dac_link_if link ();
    dac_host_end #(.P_CLEAR_CYCLES(CLR)) dac_host_end_inst (.i_mclk(i_mclk),
        .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
        .i_req_word(i_req_word), .i_req_addr(i_req_addr),
        .i_req_decode(i_req_decode), .o_req_ready(o_req_ready),
        .o_done(o_done), .link(link));
    dac_load_end dac_load_end_inst (.link(link), .o_dac_code(o_dac_code),
        .o_load_strobe_n(o_load_strobe_n));
    dac_link_props #(.P_CLEAR_CYCLES(CLR)) dac_link_props_inst (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .link_clk(link.link_clk),
        .serial_data_in(link.serial_data_in), .select_n(link.select_n),
        .clear_n(link.clear_n));

    // Host clock.
    always #(MCLK_PERIOD_NS / 2) i_mclk = ~i_mclk;

    // Wire monitors: edges, bits on falling edges, strobe low time.
    always @(posedge link.link_clk) rises++;
    always @(negedge link.link_clk) begin
        if (falls < WORD_BITS) begin
            wire_word = {wire_word[WORD_BITS-2:0], link.serial_data_in};
        end
        falls++;
    end
    always @(posedge i_mclk) if (!o_load_strobe_n) strobe_lo++;

    // ==================================================================
    // Shared tasks
    // ==================================================================
    task automatic end_of_test();
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Waits a bounded number of cycles for done (or ready) to take a value.
    task automatic wait_on(input logic pick_done, input logic val,
                           input int lim, output int n);
        logic seen;
        n = 0;
        do begin
            @(posedge i_mclk);
            #1;
            n++;
            seen = pick_done ? o_done : o_req_ready;
        end while (seen !== val && n < lim);
        if (seen !== val) begin
            bad_count++;
            $display("BAD wait expected %h seen %h", val, seen);
            end_of_test();
        end
    endtask : wait_on

    // ==================================================================
    // Scenarios
    // ==================================================================
    // Reset, outputs cleared at once, then clear released.
    task automatic do_reset();
        int n;
        @(posedge i_mclk);
        i_reset_n <= 1'b0;
        repeat (3) @(posedge i_mclk);
        #1;
        check("clear_n", 16'(link.clear_n), 16'h0000);
        check("strobe_n", 16'(o_load_strobe_n), 16'h0001);
        for (int i = 0; i < NUM_CONV; i++) begin
            exp_code[i] = WORD_ZERO;
            check("code_clr", 16'(o_dac_code[i]), 16'h0000);
        end
        @(posedge i_mclk);
        i_reset_n <= 1'b1;
        wait_on(1'b0, 1'b1, CLR + 10, n);
        check("clear_off", 16'(link.clear_n), 16'h0001);
    endtask : do_reset

    // One frame; a second word offered while busy must be ignored.
    task automatic frame(input logic [WORD_BITS-1:0] word, input logic dec,
                         input logic [ADDR_W-1:0] addr);
        int n;
        int len;
        @(posedge i_mclk);
        i_req_valid <= 1'b1;
        i_req_word <= word;
        i_req_addr <= addr;
        i_req_decode <= dec;
        wait_on(1'b0, 1'b0, 10, n);
        rises = 0;
        falls = 0;
        strobe_lo = 0;
        @(posedge i_mclk);
        i_req_word <= ~word;
        @(posedge i_mclk);
        i_req_valid <= 1'b0;
        wait_on(1'b1, 1'b1, 200, n);
        // Three phases per pulse, then the release settle, plus the select settle when decoding.
        len = 3 * int'(LINK_HALF_CYCLES) * int'(FRAME_PULSES);
        len = len + int'(SELECT_SETTLE_CYCLES) * (dec ? 2 : 1);
        check("frame_len", 16'(n + 2), 16'(len));
        check("rises", 16'(rises), 16'(FRAME_PULSES));
        check("falls", 16'(falls), 16'(FRAME_PULSES));
        check("wire_word", 16'(wire_word), 16'(word));
        check("strobe_lo", 16'(strobe_lo), 16'h0006);
        check("clk_idle", 16'(link.link_clk), 16'h0001);
        for (int i = 0; i < NUM_CONV; i++) begin
            if (!dec || addr == ADDR_W'(i)) exp_code[i] = word;
            check("dac_code", 16'(o_dac_code[i]), 16'(exp_code[i]));
        end
    endtask : frame

    // ==================================================================
    // Main sequence
    // ==================================================================
    initial begin
        do_reset();
        frame(12'hA5C, 1'b0, 2'h0);
        frame(12'h123, 1'b1, 2'h0);
        frame(12'hFED, 1'b1, 2'h1);
        frame(12'h800, 1'b1, 2'h3);
        frame(12'hFFF, 1'b0, 2'h2);
        do_reset();
        frame(12'h001, 1'b1, 2'h2);
        end_of_test();
    end
endmodule : serial_dac_load_sequencer_tb_top

`default_nettype wire
